// ==== verilog/host_port_map.svh ====
// constants for the host-side external bus controller
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH
`define CLK_PERIOD_NS 4
`define STROBE_MIN_NS 12
`define STROBE_CYC ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`define FIFO_DEPTH 16
`define WORD_W 40
`define BUS_W 48
`define ADDR_W 32
`define LANE_TOP 47
`define LANE_W32_LO 16
`define LANE_W40_LO 8
`define LANE_W16_HI 31
`define LANE_W16_LO 16
`define LANE_B8_HI 23
`define LANE_B8_LO 16
`define CORE_N 4
`define CS_IDLE 4'h0
`endif

// ==== verilog/host_port_pkg.sv ====
// types for the host-side external bus controller
`default_nettype none
package host_port_pkg;
  typedef enum logic [1:0] {w32, w40, w16, b8} width_e;
  typedef struct packed {
    logic write;
    logic [1:0] core;
    width_e width;
    logic [31:0] addr;
  } cmd_s;
  typedef enum logic [2:0] {st_idle, st_req, st_setup, st_strobe, st_hold,
    st_done} state_e;
endpackage
`default_nettype wire

// ==== verilog/external_bus_host_port.sv ====
// host controller driving the shared external bus, with write-data fifo
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.svh"

// ----------------------------------------
// write data fifo
// ----------------------------------------
module host_word_fifo #(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Operation
// - 32-bit words on lanes 47 to 16
// - 40-bit words on lanes 47 to 8
// - short words on lanes 31 to 16
// - boot bytes on lanes 23 to 16
// - master drives address, device samples on host access
// - read strobe driven by accessing party
// - store strobe driven by accessing party
// - slow memory pulls acknowledge low
// - grant held while host request stays
// - host asserts one core chip select
module external_bus_host_port (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // user command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire host_port_pkg::cmd_s cmd,
  // user write data
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [`WORD_W-1:0] wdata,
  // user read answer
  output logic rdata_valid,
  output logic [`WORD_W-1:0] rdata,
  // module bus pins
  output logic [`ADDR_W-1:0] addr_out,
  output logic addr_oe,
  input wire logic [`BUS_W-1:0] data_in,
  output logic [`BUS_W-1:0] data_out,
  output logic data_oe,
  output logic read_strobe_n,
  output logic store_strobe_n,
  output logic strobe_oe,
  output logic [`CORE_N-1:0] host_select_n,
  output logic host_bus_request_n,
  input wire logic host_bus_grant_n,
  input wire logic host_ready_out
);
  host_port_pkg::state_e state;
  host_port_pkg::state_e next_state;
  host_port_pkg::cmd_s cur;
  logic [`CNT_W-1:0] cnt;
  logic grant_m, grant_n_s, ready_m, ready_s;
  logic [`BUS_W-1:0] data_m, data_s;
  logic [`WORD_W-1:0] fifo_data;
  logic [`WORD_W-1:0] wword;
  logic fifo_valid;

  // ----------------------------------------
  // lane placement
  // ----------------------------------------
  function automatic logic [`BUS_W-1:0] pack(host_port_pkg::width_e w,
      logic [`WORD_W-1:0] d);
    logic [`BUS_W-1:0] b;
    b = '0;
    case (w)
      host_port_pkg::w32: b[`LANE_TOP:`LANE_W32_LO] = d[31:0];
      host_port_pkg::w40: b[`LANE_TOP:`LANE_W40_LO] = d;
      host_port_pkg::w16: b[`LANE_W16_HI:`LANE_W16_LO] = d[15:0];
      default: b[`LANE_B8_HI:`LANE_B8_LO] = d[7:0];
    endcase
    return b;
  endfunction

  function automatic logic [`WORD_W-1:0] unpack(host_port_pkg::width_e w,
      logic [`BUS_W-1:0] b);
    logic [`WORD_W-1:0] d;
    d = '0;
    case (w)
      host_port_pkg::w32: d[31:0] = b[`LANE_TOP:`LANE_W32_LO];
      host_port_pkg::w40: d = b[`LANE_TOP:`LANE_W40_LO];
      host_port_pkg::w16: d[15:0] = b[`LANE_W16_HI:`LANE_W16_LO];
      default: d[7:0] = b[`LANE_B8_HI:`LANE_B8_LO];
    endcase
    return d;
  endfunction

  wire accept = cmd_valid && cmd_ready;
  host_word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data(wdata),
    .out_valid(fifo_valid),
    .out_ready(accept && cmd.write),
    .out_data(fifo_data)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      grant_m <= 1'b1;
      grant_n_s <= 1'b1;
      ready_m <= 1'b1;
      ready_s <= 1'b1;
      data_m <= '0;
      data_s <= '0;
    end else begin
      grant_m <= host_bus_grant_n;
      grant_n_s <= grant_m;
      ready_m <= host_ready_out;
      ready_s <= ready_m;
      data_m <= data_in;
      data_s <= data_m;
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // writes wait for data; the last grant must clear so it is never reused
  assign cmd_ready = state == host_port_pkg::st_idle && grant_n_s
    && (!cmd.write || fifo_valid);
  wire on_bus = state == host_port_pkg::st_setup
    || state == host_port_pkg::st_strobe || state == host_port_pkg::st_hold;
  wire strobing = state == host_port_pkg::st_strobe;
  // the device stretches the strobe through its ready output
  wire strobe_end = strobing && cnt >= `CNT_W'(`STROBE_CYC - 1)
    && ready_s;

  always_comb begin
    next_state = state;
    case (state)
      host_port_pkg::st_idle:
        if (accept) next_state = host_port_pkg::st_req;
      host_port_pkg::st_req:
        if (!grant_n_s) next_state = host_port_pkg::st_setup;
      host_port_pkg::st_setup: next_state = host_port_pkg::st_strobe;
      host_port_pkg::st_strobe:
        if (strobe_end) next_state = host_port_pkg::st_hold;
      host_port_pkg::st_hold: next_state = host_port_pkg::st_done;
      host_port_pkg::st_done: next_state = host_port_pkg::st_idle;
      default: next_state = host_port_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= host_port_pkg::st_idle;
      cur <= '0;
      wword <= '0;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= strobing ? cnt + 1'b1 : '0;
      if (accept) begin
        cur <= cmd;
        wword <= fifo_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= strobe_end && !cur.write;
      if (strobe_end && !cur.write) begin
        rdata <= unpack(cur.width, data_s);
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // request stays low from accept to done, so grant never drops mid access
  assign host_bus_request_n = state == host_port_pkg::st_idle
    || state == host_port_pkg::st_done;
  assign addr_out = cur.addr;
  assign addr_oe = on_bus;
  assign data_out = pack(cur.width, wword);
  assign data_oe = on_bus && cur.write;
  assign strobe_oe = on_bus;
  assign read_strobe_n = !(strobing && !cur.write);
  assign store_strobe_n = !(strobing && cur.write);
  genvar g;
  generate
    for (g = 0; g < `CORE_N; g++) begin : g_cs
      assign host_select_n[g] = !(on_bus && cur.core == 2'(g));
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_lane_w32;
    data_oe && cur.width == host_port_pkg::w32
      |-> data_out[`LANE_TOP:`LANE_W32_LO] == wword[31:0]
        && data_out[`LANE_W32_LO-1:0] == '0;
  endproperty
  a_lane_w32: assert property (p_lane_w32) else $error("bad 32 lanes");
  property p_lane_w40;
    data_oe && cur.width == host_port_pkg::w40
      |-> data_out[`LANE_W40_LO-1:0] == '0;
  endproperty
  a_lane_w40: assert property (p_lane_w40) else $error("bad 40 lanes");
  property p_lane_w16;
    data_oe && cur.width == host_port_pkg::w16
      |-> data_out[`LANE_W16_HI:`LANE_W16_LO] == wword[15:0];
  endproperty
  a_lane_w16: assert property (p_lane_w16) else $error("bad 16 lanes");
  property p_lane_b8;
    data_oe && cur.width == host_port_pkg::b8
      |-> data_out[`LANE_B8_HI:`LANE_B8_LO] == wword[7:0];
  endproperty
  a_lane_b8: assert property (p_lane_b8) else $error("bad byte lanes");
  property p_addr_drive;
    !read_strobe_n || !store_strobe_n |-> addr_oe && strobe_oe;
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("addr float");
  property p_read_grant;
    $fell(read_strobe_n) |-> !$past(grant_n_s, 2) && !host_bus_request_n;
  endproperty
  a_read_grant: assert property (p_read_grant) else $error("rd no grant");
  property p_write_width;
    $fell(store_strobe_n) |-> (!store_strobe_n && data_oe)[*3];
  endproperty
  a_write_width: assert property (p_write_width) else $error("short wr");
  property p_req_held;
    on_bus |-> !host_bus_request_n;
  endproperty
  a_req_held: assert property (p_req_held) else $error("req dropped");
  property p_one_select;
    on_bus |-> $onehot(~host_select_n);
  endproperty
  a_one_select: assert property (p_one_select) else $error("cs count");
  property p_ready_stretch;
    strobing && !ready_s |=> strobing;
  endproperty
  a_ready_stretch: assert property (p_ready_stretch) else $error("no wait");

  c_read: cover property ($rose(rdata_valid));
  c_write: cover property ($rose(store_strobe_n) && data_oe);
  c_wait: cover property (strobing && !ready_s ##1 strobing && ready_s);
  c_full: cover property (!wdata_ready);
endmodule
`default_nettype wire

// ==== test/bus_device_model.sv ====
// behavioural processor module answering the host port
`timescale 1ns/1ps
`default_nettype none
module bus_device_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // bus from the host
  input wire logic [31:0] addr_out,
  input wire logic addr_oe,
  output logic [47:0] data_in,
  input wire logic [47:0] data_out,
  input wire logic read_strobe_n,
  input wire logic store_strobe_n,
  input wire logic strobe_oe,
  input wire logic [3:0] host_select_n,
  input wire logic host_bus_request_n,
  output logic host_bus_grant_n,
  output logic host_ready_out,
  // wait states to insert per access
  input wire logic [3:0] wait_cyc
);
  logic [47:0] mem [16];
  logic [3:0] core_seen;
  logic [3:0] cnt;
  logic [47:0] last;
  logic [31:0] addr_seen;
  wire logic sel = strobe_oe && addr_oe && host_select_n != 4'hf;
  wire logic rd = sel && !read_strobe_n;
  wire logic wr = sel && !store_strobe_n;
  // a released bus shows the inverse of its last value, never a stale copy
  assign data_in = rd ? mem[addr_out[3:0]] : ~last;
  assign host_ready_out = !(rd || wr) || cnt >= wait_cyc;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      host_bus_grant_n <= 1'b1;
      cnt <= 4'h0;
      last <= '0;
      core_seen <= 4'hf;
      addr_seen <= '0;
    end else begin
      host_bus_grant_n <= host_bus_request_n;
      cnt <= (rd || wr) && cnt != 4'hf ? cnt + 4'h1 : 4'h0;
      last <= data_in;
      if (sel) core_seen <= host_select_n;
      if (sel) addr_seen <= addr_out;
      if (wr) mem[addr_out[3:0]] <= data_out;
    end
  end
endmodule
`default_nettype wire

// ==== test/external_bus_host_port_tb.sv ====
// self-checking bench for the host-side external bus controller
`timescale 1ns/1ps
`default_nettype none
module external_bus_host_port_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic wdata_valid = 1'b0;
  logic [39:0] wdata = '0;
  host_port_pkg::cmd_s cmd = '0;
  logic [3:0] wait_cyc = 4'h0;
  logic cmd_ready, wdata_ready, rdata_valid, addr_oe, data_oe, strobe_oe;
  logic read_strobe_n, store_strobe_n, host_bus_request_n;
  logic host_bus_grant_n, host_ready_out;
  logic [39:0] rdata;
  logic [31:0] addr_out;
  logic [47:0] data_in, data_out;
  logic [3:0] host_select_n;
  int failures = 0;
  int checks_done = 0;
  int lat;
  external_bus_host_port dut (.clk_sys, .reset_n, .cmd_valid, .cmd_ready,
    .cmd, .wdata_valid, .wdata_ready, .wdata, .rdata_valid, .rdata,
    .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .read_strobe_n,
    .store_strobe_n, .strobe_oe, .host_select_n, .host_bus_request_n,
    .host_bus_grant_n, .host_ready_out);
  bus_device_model dev (.clk_sys, .reset_n, .addr_out, .addr_oe, .data_in,
    .data_out, .read_strobe_n, .store_strobe_n, .strobe_oe, .host_select_n,
    .host_bus_request_n, .host_bus_grant_n, .host_ready_out, .wait_cyc);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [47:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait, sampled just after the edge so updates have landed
  task automatic await(ref logic s);
    lat = 0;
    while (s !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      if (++lat > 300) begin
        failures++;
        close_out();
      end
    end
  endtask
  function automatic logic [47:0] lanes(host_port_pkg::width_e w,
      logic [39:0] d);
    case (w)
      host_port_pkg::w32: return {d[31:0], 16'h0000};
      host_port_pkg::w40: return {d, 8'h00};
      host_port_pkg::w16: return {16'h0000, d[15:0], 16'h0000};
      default: return {24'h00_0000, d[7:0], 16'h0000};
    endcase
  endfunction
  task automatic push(input logic [39:0] d);
    await(wdata_ready);
    @(posedge clk_sys);
    wdata_valid <= 1'b1;
    wdata <= d;
    @(posedge clk_sys);
    wdata_valid <= 1'b0;
  endtask
  task automatic access(input logic wr, input logic [1:0] core,
      input host_port_pkg::width_e w, input logic [31:0] a);
    int n;
    await(cmd_ready);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{wr, core, w, a};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd.write <= 1'b0;
    #1;
    if (!wr) await(rdata_valid);
    n = lat;
    await(cmd_ready);
    lat = n;
    check("bus released", {host_bus_request_n, addr_oe, data_oe, strobe_oe},
      4'h8);
  endtask
  task automatic lanes_test;
    host_port_pkg::width_e w;
    logic [39:0] d;
    for (int i = 0; i < 4; i++) begin
      w = host_port_pkg::width_e'(i);
      d = 40'h9a_5c3e_71b4 + 40'(i);
      push(d);
      access(1'b1, i[1:0], w, 32'h0000_0020 + 32'(i));
      check("stored lanes", dev.mem[i], lanes(w, d));
      check("core select", dev.core_seen, 4'hf ^ (4'h1 << i));
      check("address", dev.addr_seen, 32'h0000_0020 + 32'(i));
      access(1'b0, i[1:0], w, 32'h0000_0020 + 32'(i));
      check("read word", rdata, lanes(w, d) >> (i == 1 ? 8 : 16));
    end
  endtask
  // fill to refusal, then drain against a stalling device
  task automatic fifo_test;
    @(posedge clk_sys);
    for (int i = 0; i < 16; i++) begin
      wdata_valid <= 1'b1;
      wdata <= 40'h00_0000_0100 + 40'(i);
      @(posedge clk_sys);
    end
    wdata_valid <= 1'b0;
    wait_cyc <= 4'h6;
    #1;
    check("fifo full", wdata_ready, 1'b0);
    for (int i = 0; i < 16; i++)
      access(1'b1, 2'h2, host_port_pkg::w40, 32'(i));
    for (int i = 0; i < 16; i++)
      check("fifo order", dev.mem[i], {40'h00_0000_0100 + 40'(i), 8'h00});
  endtask
  task automatic ready_test;
    int fast;
    @(posedge clk_sys);
    wait_cyc <= 4'h0;
    access(1'b0, 2'h3, host_port_pkg::w40, 32'h0000_0003);
    fast = lat;
    @(posedge clk_sys);
    wait_cyc <= 4'h9;
    access(1'b0, 2'h3, host_port_pkg::w40, 32'h0000_0003);
    check("wait stretch", lat >= fast + 6, 1'b1);
    check("slow read", rdata, 40'h00_0000_0103);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("idle pins", {addr_oe, data_oe, strobe_oe, read_strobe_n,
      store_strobe_n, host_select_n, host_bus_request_n, rdata_valid},
      11'h0fe);
    lanes_test();
    fifo_test();
    ready_test();
    close_out();
  end
endmodule
`default_nettype wire
